// ==== rtl/cac_pkg.sv ====
/*
  constants for the charger and converter register bank: addresses,
  reset values, write masks, field positions, channel codes, timing.
  assumes an 8-bit register port driven by the serial interface engine.
*/
package cac_pkg;
  // register addresses
  localparam logic [7:0] CAC_ADDR_MAIN   = 8'h04;
  localparam logic [7:0] CAC_ADDR_TIMING = 8'h05;
  localparam logic [7:0] CAC_ADDR_PATH   = 8'h06;
  localparam logic [7:0] CAC_ADDR_CONV   = 8'h07;
  // values loaded at undervoltage lockout (reset)
  localparam logic [7:0] CAC_RST_MAIN    = 8'h11;
  localparam logic [7:0] CAC_RST_TIMING  = 8'he0;
  localparam logic [7:0] CAC_RST_PATH    = 8'h64;
  localparam logic [7:0] CAC_RST_CONV    = 8'h20;
  // bits that software may write
  localparam logic [7:0] CAC_WM_MAIN     = 8'h1f;
  localparam logic [7:0] CAC_WM_TIMING   = 8'hf0;
  localparam logic [7:0] CAC_WM_PATH     = 8'hfd;
  localparam logic [7:0] CAC_WM_CONV     = 8'hdf;
  // main control fields
  localparam int CAC_MAIN_SENSOR = 4;
  localparam int CAC_MAIN_RESET  = 3;
  localparam int CAC_MAIN_TERMDIS = 2;
  localparam int CAC_MAIN_SUSP   = 1;
  localparam int CAC_MAIN_EN     = 0;
  // timing and voltage fields
  localparam int CAC_TIM_DYN     = 7;
  localparam int CAC_TIM_PREV    = 6;
  localparam int CAC_TIM_VSEL_HI = 5;
  localparam int CAC_TIM_VSEL_LO = 4;
  // power path and termination fields
  localparam int CAC_PATH_ACSINK = 7;
  localparam int CAC_PATH_THR_HI = 6;
  localparam int CAC_PATH_THR_LO = 5;
  localparam int CAC_PATH_PRET   = 4;
  localparam int CAC_PATH_TRM_HI = 3;
  localparam int CAC_PATH_TRM_LO = 2;
  localparam int CAC_PATH_ACTIVE = 1;
  localparam int CAC_PATH_USBSNK = 0;
  // converter control fields
  localparam int CAC_CONV_EN     = 7;
  localparam int CAC_CONV_START  = 6;
  localparam int CAC_CONV_EOC    = 5;
  localparam int CAC_CONV_VREF   = 4;
  localparam int CAC_CONV_SEL_HI = 3;
  localparam int CAC_CONV_SEL_LO = 0;
  // input select codes
  localparam logic [3:0] CAC_CH_FIRST_HIGH = 4'h6;
  localparam logic [3:0] CAC_CH_LAST_HIGH  = 4'hc;
  localparam logic [3:0] CAC_CH_RESERVED   = 4'hd;
  // safety timer base tick
  localparam int CAC_CLK_PERIOD_NS = 25;
  localparam int CAC_TICK_US       = 100;
  localparam int CAC_TICK_CYCLES   = (CAC_TICK_US * 1000) / CAC_CLK_PERIOD_NS;

  typedef enum logic {
    CAC_ADC_IDLE = 1'b0,
    CAC_ADC_BUSY = 1'b1
  } cac_adc_state_type;

  // codes six to twelve select the 6.0 V full-scale range
  function automatic logic cac_high_range(input logic [3:0] sel);
    cac_high_range = (sel >= CAC_CH_FIRST_HIGH) && (sel <= CAC_CH_LAST_HIGH);
  endfunction
endpackage

// ==== rtl/cac_sync2.sv ====
/*
  two-flop synchroniser for analog status levels.
  assumes the inputs are slow levels from the charger's analog section.
*/
`timescale 1ns/10ps
module cac_sync2 import cac_pkg::*; #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ==== rtl/cac_adc_seq.sv ====
/*
  conversion sequencer: owns the start and end-of-conversion bits.
  assumes conv_done_in is a one-cycle pulse from the converter on this clock.
*/
`timescale 1ns/10ps
module cac_adc_seq import cac_pkg::*; (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic start_wr_in,
  input  wire logic start_val_in,
  input  wire logic enable_in,
  input  wire logic conv_done_in,
  output logic      start_bit_out,
  output logic      eoc_out,
  output logic      conv_start_out
);
  cac_adc_state_type state_q;

  // sequence: start bit and enable launch, done pulse finishes
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q        <= CAC_ADC_IDLE;
      start_bit_out  <= 1'b0;
      eoc_out        <= 1'b1;
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      case (state_q)
        CAC_ADC_IDLE: begin
          if (start_wr_in) begin
            start_bit_out <= start_val_in;
          end
          if (start_bit_out && enable_in && !start_wr_in) begin
            state_q        <= CAC_ADC_BUSY;
            eoc_out        <= 1'b0;
            conv_start_out <= 1'b1;
          end
        end
        CAC_ADC_BUSY: begin
          if (!enable_in) begin
            state_q       <= CAC_ADC_IDLE; // converter powered down aborts
            start_bit_out <= 1'b0;
          end else if (conv_done_in) begin
            state_q       <= CAC_ADC_IDLE;
            start_bit_out <= start_wr_in && start_val_in; // new start wins
            eoc_out       <= 1'b1;
          end
        end
        default: state_q <= CAC_ADC_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  start_clear_a: assert property ((state_q == CAC_ADC_BUSY) && enable_in && conv_done_in && !start_wr_in
    |=> !start_bit_out && eoc_out) else $error("start bit not cleared at done");
  eoc_low_a: assert property (conv_start_out |-> !eoc_out ##1 !eoc_out)
    else $error("done flag high during conversion");
  cover_conv_c: cover property (conv_start_out ##[1:50] eoc_out);
endmodule

// ==== rtl/cac_regs.sv ====
/*
  charger and converter configuration register bank with its decoded
  controls, safety timer tick and conversion launch.
  assumes an 8-bit register port from the serial interface engine on
  ref_clk_in, and analog status levels that need synchronising.
*/
// Functional notes
// - sensor bit picks thermistor curve: 0 is 100k curve 1, 1 is 10k curve 2.
// - host sets then clears charger reset; charger held in reset while set.
// - termination disable 0 ends charge on timers/current; 1 keeps charger on.
// - suspend bit pauses safety and precharge timers; they run when clear.
// - enable bit switches charger; toggling it never resets the algorithm.
// - dynamic timer bit halves timer rate while thermal or power-path loop active.
// - precharge threshold bit: 0 selects 2.5 V, 1 selects 2.9 V.
// - charge voltage field selects 4.1, 4.15, 4.2 or 4.25 V.
// - AC sink-disable 0 enables 60 uA sink when no AC voltage.
// - USB sink likewise; each sink turns off once its input voltage appears.
// - power-path field selects 3.5, 3.75, 4.25 or 4.50 V threshold.
// - precharge time bit: 0 gives 30 min, 1 gives 60 min.
// - termination factor field selects 0.04, 0.1, 0.15 or 0.2.
// - charging status bit reads 1 while charging, even under regulation.
// - converter enable bit powers the converter.
// - host writes start; hardware clears it when conversion finishes.
// - done flag reads 0 until conversion completes; resets to 1.
// - reference enable bit switches the converter reference regulator.
// - select codes 0-5 use 2.25 V range, codes 6-12 use 6.0 V.
// - codes 14 and 15 route the touch panel controller at 2.25 V.
// - main charger control register lives at address 04h.
`timescale 1ns/10ps
module cac_regs import cac_pkg::*; #(
  parameter int TICK_CYCLES = CAC_TICK_CYCLES
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       ac_present_in,
  input  wire logic       usb_present_in,
  input  wire logic       thermal_loop_in,
  input  wire logic       dynamic_power_path_loop_in,
  input  wire logic       charging_in,
  input  wire logic       conv_done_in,
  output logic            sensor_curve2_out,
  output logic            charger_hold_reset_out,
  output logic            term_disable_out,
  output logic            timer_suspend_out,
  output logic            charger_enable_out,
  output logic            safety_tick_out,
  output logic            timer_half_rate_out,
  output logic            precharge_hi_thresh_out,
  output logic      [1:0] charge_voltage_sel_out,
  output logic      [1:0] power_path_thresh_out,
  output logic            precharge_long_out,
  output logic      [1:0] term_factor_sel_out,
  output logic            ac_sink_on_out,
  output logic            usb_sink_on_out,
  output logic            converter_enable_out,
  output logic            vref_enable_out,
  output logic      [3:0] input_select_out,
  output logic            fullscale_high_out,
  output logic            conv_start_out
);
  initial begin
    if (TICK_CYCLES < 2) begin
      $error("TICK_CYCLES must be at least 2");
    end
  end

  logic [7:0]  main_q;
  logic [7:0]  timing_q;
  logic [7:0]  path_q;
  logic [7:0]  conv_q;
  logic [4:0]  stat_sync;
  logic        ac_sync;
  logic        usb_sync;
  logic        therm_sync;
  logic        path_loop_sync;
  logic        chg_sync;
  logic        start_bit;
  logic        eoc_bit;
  logic        slow_d;
  logic [31:0] tick_limit;
  logic [31:0] tick_cnt_q;

  // analog status levels cross into the clock domain
  cac_sync2 #(
    .WIDTH(5)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in    (rst_in),
    .async_in  ({ac_present_in, usb_present_in, thermal_loop_in,
                 dynamic_power_path_loop_in, charging_in}),
    .sync_out  (stat_sync)
  );
  assign ac_sync    = stat_sync[4];
  assign usb_sync   = stat_sync[3];
  assign therm_sync = stat_sync[2];
  assign path_loop_sync = stat_sync[1];
  assign chg_sync   = stat_sync[0];

  // write decode for main charger control
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      main_q <= CAC_RST_MAIN;
    end else if (reg_wr_in && reg_addr_in == CAC_ADDR_MAIN) begin
      main_q <= reg_wdata_in & CAC_WM_MAIN;
    end
  end

  // write decode for timing and voltage config
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timing_q <= CAC_RST_TIMING;
    end else if (reg_wr_in && reg_addr_in == CAC_ADDR_TIMING) begin
      timing_q <= reg_wdata_in & CAC_WM_TIMING;
    end
  end

  // write decode for power path and termination config
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      path_q <= CAC_RST_PATH;
    end else if (reg_wr_in && reg_addr_in == CAC_ADDR_PATH) begin
      path_q <= reg_wdata_in & CAC_WM_PATH;
    end
  end

  // write decode for converter control; start and done live in the sequencer
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_q <= CAC_RST_CONV;
    end else if (reg_wr_in && reg_addr_in == CAC_ADDR_CONV) begin
      conv_q <= reg_wdata_in & CAC_WM_CONV;
    end
  end

  // conversion launch and completion
  cac_adc_seq u_adc (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .start_wr_in   (reg_wr_in && reg_addr_in == CAC_ADDR_CONV),
    .start_val_in  (reg_wdata_in[CAC_CONV_START]),
    .enable_in     (conv_q[CAC_CONV_EN]),
    .conv_done_in  (conv_done_in),
    .start_bit_out (start_bit),
    .eoc_out       (eoc_bit),
    .conv_start_out(conv_start_out)
  );

  // read mux, registered; unmapped addresses read zero
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        CAC_ADDR_MAIN:   reg_rdata_out <= main_q;
        CAC_ADDR_TIMING: reg_rdata_out <= timing_q;
        CAC_ADDR_PATH: begin
          reg_rdata_out                  <= path_q;
          reg_rdata_out[CAC_PATH_ACTIVE] <= chg_sync;
        end
        CAC_ADDR_CONV: begin
          reg_rdata_out                 <= conv_q;
          reg_rdata_out[CAC_CONV_START] <= start_bit;
          reg_rdata_out[CAC_CONV_EOC]   <= eoc_bit;
        end
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // charger control outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sensor_curve2_out      <= CAC_RST_MAIN[CAC_MAIN_SENSOR];
      charger_hold_reset_out <= CAC_RST_MAIN[CAC_MAIN_RESET];
      term_disable_out       <= CAC_RST_MAIN[CAC_MAIN_TERMDIS];
      timer_suspend_out      <= CAC_RST_MAIN[CAC_MAIN_SUSP];
      charger_enable_out     <= CAC_RST_MAIN[CAC_MAIN_EN];
    end else begin
      sensor_curve2_out      <= main_q[CAC_MAIN_SENSOR];
      charger_hold_reset_out <= main_q[CAC_MAIN_RESET];
      term_disable_out       <= main_q[CAC_MAIN_TERMDIS];
      timer_suspend_out      <= main_q[CAC_MAIN_SUSP];
      charger_enable_out     <= main_q[CAC_MAIN_EN];
    end
  end

  // threshold and selection outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      precharge_hi_thresh_out <= CAC_RST_TIMING[CAC_TIM_PREV];
      charge_voltage_sel_out  <= CAC_RST_TIMING[CAC_TIM_VSEL_HI:CAC_TIM_VSEL_LO];
      power_path_thresh_out   <= CAC_RST_PATH[CAC_PATH_THR_HI:CAC_PATH_THR_LO];
      precharge_long_out      <= CAC_RST_PATH[CAC_PATH_PRET];
      term_factor_sel_out     <= CAC_RST_PATH[CAC_PATH_TRM_HI:CAC_PATH_TRM_LO];
    end else begin
      precharge_hi_thresh_out <= timing_q[CAC_TIM_PREV];
      charge_voltage_sel_out  <= timing_q[CAC_TIM_VSEL_HI:CAC_TIM_VSEL_LO];
      power_path_thresh_out   <= path_q[CAC_PATH_THR_HI:CAC_PATH_THR_LO];
      precharge_long_out      <= path_q[CAC_PATH_PRET];
      term_factor_sel_out     <= path_q[CAC_PATH_TRM_HI:CAC_PATH_TRM_LO];
    end
  end

  // input pull-down sinks: on when enabled and no voltage sensed
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ac_sink_on_out  <= 1'b0;
      usb_sink_on_out <= 1'b0;
    end else begin
      ac_sink_on_out  <= !path_q[CAC_PATH_ACSINK] && !ac_sync;
      usb_sink_on_out <= !path_q[CAC_PATH_USBSNK] && !usb_sync;
    end
  end

  // converter controls and range
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      converter_enable_out <= CAC_RST_CONV[CAC_CONV_EN];
      vref_enable_out      <= CAC_RST_CONV[CAC_CONV_VREF];
      input_select_out     <= CAC_RST_CONV[CAC_CONV_SEL_HI:CAC_CONV_SEL_LO];
      fullscale_high_out   <= 1'b0;
    end else begin
      converter_enable_out <= conv_q[CAC_CONV_EN];
      vref_enable_out      <= conv_q[CAC_CONV_VREF];
      input_select_out     <= conv_q[CAC_CONV_SEL_HI:CAC_CONV_SEL_LO];
      fullscale_high_out   <= cac_high_range(conv_q[CAC_CONV_SEL_HI:CAC_CONV_SEL_LO]);
    end
  end

  // safety timer tick: period doubles under dynamic timing with a loop active
  assign slow_d     = timing_q[CAC_TIM_DYN] && (therm_sync || path_loop_sync);
  assign tick_limit = slow_d ? 32'(2 * TICK_CYCLES - 1) : 32'(TICK_CYCLES - 1);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_q          <= 32'h0000_0000;
      safety_tick_out     <= 1'b0;
      timer_half_rate_out <= 1'b0;
    end else begin
      timer_half_rate_out <= slow_d;
      safety_tick_out     <= 1'b0;
      if (main_q[CAC_MAIN_RESET]) begin
        tick_cnt_q <= 32'h0000_0000; // timers restart with the algorithm
      end else if (!main_q[CAC_MAIN_SUSP]) begin
        if (tick_cnt_q >= tick_limit) begin
          tick_cnt_q      <= 32'h0000_0000;
          safety_tick_out <= 1'b1;
        end else begin
          tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // register writes land one edge after the strobe
  main_write_a: assert property (reg_wr_in && reg_addr_in == CAC_ADDR_MAIN
    |=> main_q == ($past(reg_wdata_in) & CAC_WM_MAIN)) else $error("main register write lost");

  // charger control fields follow the main register
  sensor_out_a: assert property (reg_wr_in && reg_addr_in == CAC_ADDR_MAIN
    |=> ##1 sensor_curve2_out == $past(reg_wdata_in[CAC_MAIN_SENSOR], 2)) else $error("sensor select wrong");

  hold_reset_a: assert property (main_q[CAC_MAIN_RESET] |=> charger_hold_reset_out && !safety_tick_out)
    else $error("charger not held in reset");

  tick_clear_a: assert property (main_q[CAC_MAIN_RESET] |=> tick_cnt_q == 32'h0000_0000)
    else $error("timer not cleared in reset");

  term_out_a: assert property (term_disable_out == $past(main_q[CAC_MAIN_TERMDIS]))
    else $error("termination disable wrong");

  // reset has priority over suspend, so only a plain suspend freezes the count
  suspend_tick_a: assert property (main_q[CAC_MAIN_SUSP] && !main_q[CAC_MAIN_RESET]
    |=> !safety_tick_out && $stable(tick_cnt_q)) else $error("timer ran while suspended");

  enable_keep_a: assert property ($changed(main_q[CAC_MAIN_EN]) && !main_q[CAC_MAIN_RESET]
    |=> !charger_hold_reset_out) else $error("enable toggle reset charger");

  // timing and voltage selections
  half_rate_a: assert property (timing_q[CAC_TIM_DYN] && therm_sync |=> timer_half_rate_out)
    else $error("timer rate not halved");

  prev_out_a: assert property (precharge_hi_thresh_out == $past(timing_q[CAC_TIM_PREV]))
    else $error("precharge threshold wrong");

  vsel_out_a: assert property (charge_voltage_sel_out == $past(timing_q[CAC_TIM_VSEL_HI:CAC_TIM_VSEL_LO]))
    else $error("charge voltage select wrong");

  // input sinks: AC off once a voltage is sensed, USB on while enabled and none sensed
  ac_sink_a: assert property (ac_sync || path_q[CAC_PATH_ACSINK] |=> !ac_sink_on_out)
    else $error("ac sink left on");

  usb_sink_a: assert property (!usb_sync && !path_q[CAC_PATH_USBSNK] |=> usb_sink_on_out)
    else $error("usb sink not on");

  // power path and termination selections
  path_thr_a: assert property (power_path_thresh_out == $past(path_q[CAC_PATH_THR_HI:CAC_PATH_THR_LO]))
    else $error("power path threshold wrong");

  pre_time_a: assert property (precharge_long_out == $past(path_q[CAC_PATH_PRET]))
    else $error("precharge time wrong");

  term_fac_a: assert property (term_factor_sel_out == $past(path_q[CAC_PATH_TRM_HI:CAC_PATH_TRM_LO]))
    else $error("termination factor wrong");

  chg_read_a: assert property (reg_rd_in && reg_addr_in == CAC_ADDR_PATH
    |=> reg_rdata_out[CAC_PATH_ACTIVE] == $past(chg_sync)) else $error("charging status misread");

  // converter controls and range
  conv_en_a: assert property (conv_start_out |-> $past(conv_q[CAC_CONV_EN]))
    else $error("conversion without enable");

  vref_out_a: assert property (vref_enable_out == $past(conv_q[CAC_CONV_VREF]))
    else $error("reference enable wrong");

  range_touch_a: assert property (conv_q[CAC_CONV_SEL_HI:CAC_CONV_SEL_LO] >= 4'he |=> !fullscale_high_out)
    else $error("touch panel range wrong");

  range_hi_a: assert property (conv_q[CAC_CONV_SEL_HI:CAC_CONV_SEL_LO] == CAC_CH_FIRST_HIGH
    |=> fullscale_high_out) else $error("high range not selected");

  // the unassigned code keeps the narrow range
  range_resv_a: assert property (conv_q[CAC_CONV_SEL_HI:CAC_CONV_SEL_LO] == CAC_CH_RESERVED
    |=> !fullscale_high_out) else $error("reserved code range wrong");

  // main scenarios worth seeing

  cover_tick_c: cover property (safety_tick_out ##1 !safety_tick_out [*3]);
  cover_slow_c: cover property (timer_half_rate_out && safety_tick_out);
  cover_reset_c: cover property ($rose(charger_hold_reset_out) ##[1:20] $fell(charger_hold_reset_out));
endmodule

// ==== tb/cac_host_model.sv ====
/*
  host and converter stand-in: byte register cycles and a done pulse.
  assumes the bank takes a strobe on the rising edge of ref_clk_in.
*/
`timescale 1ns/10ps
module cac_host_model (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       conv_start_in,
  input  wire logic       conv_en_in,
  input  wire logic [7:0] done_delay_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic            done_out
);
  // idle bus at time zero
  initial begin
    {addr_out, wdata_out, wr_out, rd_out, done_out} = '0;
  end
  // one write strobe; released lines show inverted bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // one read strobe, data taken one edge after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge ref_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge ref_clk_in);
    d = rdata_in;
  endtask
  // converter answers after a delay unless powered down meanwhile
  always begin
    @(posedge ref_clk_in);
    if (conv_start_in) begin
      for (int i = 0; i < done_delay_in && conv_en_in; i++) @(posedge ref_clk_in);
      done_out <= conv_en_in;
      @(posedge ref_clk_in);
      done_out <= 1'b0;
    end
  end
endmodule

// ==== tb/tb_charger_adc_config_regs.sv ====
/*
  self-checking bench for the charger and converter register bank.
  assumes cac_pkg is compiled and the host model drives the register port.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_charger_adc_config_regs;
  import cac_pkg::*;
  localparam int TCK = 6;
  int          err_total = 0, tests_run = 0;
  logic        clk = 0, rst = 1, ac_p = 0, usb_p = 0, therm = 0, dpp = 0, chg = 0;
  logic [7:0]  addr, wdata, rdata, rv, w, a, dly = 8'h14;
  logic [31:0] seed = 32'd37298, r;
  logic        wr, rd, done, tick, cst, sc2, hold, tdis, susp, cen, half, phi, plong, acs, usbs, ven, vref, fsh;
  logic [1:0]  cvs, ppt, tfs;
  logic [3:0]  sel;
  logic [7:0]  rstv [5] = '{8'h11, 8'he0, 8'h64, 8'h20, 8'h00};
  // clock at 40 MHz
  always #12.5 clk = ~clk;
  cac_regs #(.TICK_CYCLES(TCK)) dut (.ref_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .ac_present_in(ac_p),
    .usb_present_in(usb_p), .thermal_loop_in(therm), .dynamic_power_path_loop_in(dpp), .charging_in(chg),
    .conv_done_in(done), .sensor_curve2_out(sc2), .charger_hold_reset_out(hold), .term_disable_out(tdis),
    .timer_suspend_out(susp), .charger_enable_out(cen), .safety_tick_out(tick), .timer_half_rate_out(half),
    .precharge_hi_thresh_out(phi), .charge_voltage_sel_out(cvs), .power_path_thresh_out(ppt),
    .precharge_long_out(plong), .term_factor_sel_out(tfs), .ac_sink_on_out(acs), .usb_sink_on_out(usbs),
    .converter_enable_out(ven), .vref_enable_out(vref), .input_select_out(sel), .fullscale_high_out(fsh),
    .conv_start_out(cst));
  cac_host_model host (.ref_clk_in(clk), .rdata_in(rdata), .conv_start_in(cst), .conv_en_in(ven),
    .done_delay_in(dly), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .done_out(done));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // read-back image: unbuilt bits 0, status bits from the inputs, done flag set
  function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic [7:0] d);
    case (ad)
      8'h04: return {3'h0, d[4:0]};
      8'h05: return {d[7:4], 4'h0};
      8'h06: return {d[7:2], chg, d[0]};
      8'h07: return {d[7], 2'b01, d[4:0]};
      default: return 8'h00;
    endcase
  endfunction
  // codes six to twelve use the wide range
  function automatic logic exp_fs(input logic [3:0] s);
    return (s >= 4'h6) && (s <= 4'hc);
  endfunction
  // cycles between two timer ticks
  task automatic gap(output int g);
    for (int i = 0; i < 60 && tick !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    for (g = 1; g < 60 && tick !== 1'b1; g++) @(posedge clk);
  endtask
  // ticks seen over 40 cycles
  task automatic cnt(output int c);
    c = 0;
    repeat (40) begin
      @(posedge clk);
      c += (tick === 1'b1);
    end
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // main sequence
  initial begin
    int g;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rstv[i]) begin
      host.rd(8'h04 + 8'(i), rv);
      `CHK(rv, rstv[i])
    end
    $display("test reset_image done");
    for (int n = 0; n < 40; n++) begin
      r = rnd();
      a = {6'h01, r[1:0]};
      w = r[15:8];
      if (a == 8'h07) w[6] = 1'b0;
      if (a == 8'h07 && w[3:0] == 4'hd) w[3:0] = 4'hc;
      ac_p <= r[16];
      usb_p <= r[17];
      chg <= r[18];
      dpp <= r[19];
      therm <= r[20];
      host.wr(a, w);
      repeat (4) @(posedge clk);
      host.rd(a, rv);
      `CHK(rv, exp_rd(a, w))
      case (a)
        8'h04: `CHK({sc2, hold, tdis, susp, cen}, w[4:0])
        8'h05: `CHK({phi, cvs}, w[6:4])
        8'h06: `CHK({ppt, plong, tfs, acs, usbs}, {w[6:2], ~w[7] & ~ac_p, ~w[0] & ~usb_p})
        default: `CHK({ven, vref, sel, fsh}, {w[7], w[4:0], exp_fs(w[3:0])})
      endcase
    end
    $display("test random_access done");
    for (int k = 0; k < 16; k++) begin
      if (k == 13) continue;
      host.wr(8'h07, {4'h0, 4'(k)});
      repeat (3) @(posedge clk);
      `CHK(fsh, exp_fs(4'(k)))
    end
    host.wr(8'h07, 8'hc2);
    for (int i = 0; i < 10 && cst !== 1'b1; i++) @(posedge clk);
    `CHK(cst, 1'b1)
    host.rd(8'h07, rv);
    `CHK(rv, 8'hc2)
    repeat (30) @(posedge clk);
    host.rd(8'h07, rv);
    `CHK(rv, 8'ha2)
    dly <= 8'h28;
    host.wr(8'h07, 8'hc2);
    repeat (5) @(posedge clk);
    host.wr(8'h07, 8'h02);
    repeat (50) @(posedge clk);
    host.rd(8'h07, rv);
    `CHK(rv, 8'h02)
    $display("test conversion done");
    therm <= 1'b1;
    dpp <= 1'b0;
    host.wr(8'h04, 8'h11);
    host.wr(8'h05, 8'h60);
    gap(g);
    `CHK(g, TCK)
    host.wr(8'h04, 8'h19);
    repeat (3) @(posedge clk);
    `CHK(hold, 1'b1)
    cnt(g);
    `CHK(g, 0)
    host.wr(8'h04, 8'h11);
    host.wr(8'h04, 8'h13);
    cnt(g);
    `CHK(g, 0)
    therm <= 1'b0;
    dpp <= 1'b1;
    host.wr(8'h04, 8'h11);
    host.wr(8'h05, 8'he0);
    repeat (4) @(posedge clk);
    `CHK(half, 1'b1)
    gap(g);
    gap(g);
    `CHK(g, 2 * TCK)
    $display("test timers done");
    report_and_stop();
  end
endmodule
